// >>> hdl/famsr_regs.sv
// Fault and alert mask bytes, general and phase status bytes, and the fault and alert outputs.
//
// How it works
// - alert mask bit 3 blocks comm/memory/logic alerts
// - mask bit 2 blocks auxiliary voltage limit alerts
// - alert mask bit 0 blocks output power alerts
// - fault mask read/write, resets zero, bit 7
// - fault mask bit 6 blocks output current faults
// - fault mask bit 3 blocks comm/memory/logic faults
// - fault mask bit 0 blocks output power faults
// - power good reported at status word bit 3
// - phase status bit 5 shows fourth phase
// - phase status bit 4 shows third phase
// - phase status bit 3 shows second phase
// - phase status bit 2 shows power save
`timescale 1ns/100ps

module famsr_regs (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Command port from the serial management interface
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_wdata_i,
    // Command answer
    output logic rsp_valid_o,
    output logic [7:0] rsp_rdata_o,
    output logic rsp_err_o,
    // Monitored conditions from the regulator
    input wire logic output_voltage_flag_i,
    input wire logic output_current_flag_i,
    input wire logic comm_memory_logic_status_i,
    input wire logic aux_voltage_monitor_flag_i,
    input wire logic output_power_flag_i,
    input wire logic power_good_i,
    input wire logic ready_i,
    // Phase configuration and power save pin
    input wire logic phase2_en_i,
    input wire logic phase3_en_i,
    input wire logic phase4_en_i,
    input wire logic power_save_request_n_i,
    // Indications
    output logic fault_o,
    output logic alert_o
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [famsr_pkg::SRC_COUNT-1:0] pins_raw; // Pins gathered into one vector.
    logic [famsr_pkg::SRC_COUNT-1:0] pins_s;   // Settled pin levels.

    assign pins_raw[famsr_pkg::SRC_OVOLT] = output_voltage_flag_i;
    assign pins_raw[famsr_pkg::SRC_OCURR] = output_current_flag_i;
    assign pins_raw[famsr_pkg::SRC_CMEM] = comm_memory_logic_status_i;
    assign pins_raw[famsr_pkg::SRC_AUXV] = aux_voltage_monitor_flag_i;
    assign pins_raw[famsr_pkg::SRC_OPWR] = output_power_flag_i;
    assign pins_raw[famsr_pkg::SRC_PGOOD] = power_good_i;
    assign pins_raw[famsr_pkg::SRC_READY] = ready_i;
    assign pins_raw[famsr_pkg::SRC_PH2] = phase2_en_i;
    assign pins_raw[famsr_pkg::SRC_PH3] = phase3_en_i;
    assign pins_raw[famsr_pkg::SRC_PH4] = phase4_en_i;
    assign pins_raw[famsr_pkg::SRC_PSAVE_N] = power_save_request_n_i;

    // All pins come from the analog side, so every one passes the synchroniser.
    famsr_sync #(
        .WIDTH(famsr_pkg::SRC_COUNT),
        .RST_VAL(famsr_pkg::SRC_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    // Named views of the settled levels.
    logic ovolt_s;     // Output voltage group flag.
    logic ocurr_s;     // Output current group flag.
    logic cmem_s;      // Communication, memory and logic group flag.
    logic auxv_s;      // Auxiliary voltage outside its limits.
    logic opwr_s;      // Output power over its limit.
    logic pgood_s;     // Power good.
    logic ready_s;     // Device ready.
    logic psave_s;     // Power save request asserted, active high here.

    assign ovolt_s = pins_s[famsr_pkg::SRC_OVOLT];
    assign ocurr_s = pins_s[famsr_pkg::SRC_OCURR];
    assign cmem_s = pins_s[famsr_pkg::SRC_CMEM];
    assign auxv_s = pins_s[famsr_pkg::SRC_AUXV];
    assign opwr_s = pins_s[famsr_pkg::SRC_OPWR];
    assign pgood_s = pins_s[famsr_pkg::SRC_PGOOD];
    assign ready_s = pins_s[famsr_pkg::SRC_READY];
    assign psave_s = ~pins_s[famsr_pkg::SRC_PSAVE_N];

    // ------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------
    logic [7:0] alert_mask_ff; // Alert mask byte.
    logic [7:0] fault_mask_ff; // Fault mask byte.
    logic wr_alert;            // Write to the alert mask this cycle.
    logic wr_fault;            // Write to the fault mask this cycle.

    assign wr_alert = cmd_valid_i && cmd_write_i && (cmd_code_i == famsr_pkg::CMD_ALERT_MASK);
    assign wr_fault = cmd_valid_i && cmd_write_i && (cmd_code_i == famsr_pkg::CMD_FAULT_MASK);

    // Alert mask: only implemented bits take the written value.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            alert_mask_ff <= famsr_pkg::ALERT_MASK_RST;
        end
        else if (wr_alert)
        begin
            alert_mask_ff <= cmd_wdata_i & famsr_pkg::ALERT_MASK_WR;
        end
    end

    // Fault mask: read/write byte that clears on reset.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            fault_mask_ff <= famsr_pkg::FAULT_MASK_RST;
        end
        else if (wr_fault)
        begin
            fault_mask_ff <= cmd_wdata_i & famsr_pkg::FAULT_MASK_WR;
        end
    end

    // ------------------------------------------------------------------
    // Fault and alert generation
    // ------------------------------------------------------------------
    logic nxt_fault; // Fault from unmasked sources.
    logic nxt_alert; // Alert from unmasked sources.
    logic auxv_masked; // Either mask byte silences the voltage monitor.

    assign auxv_masked = alert_mask_ff[famsr_pkg::MASK_AUXV_BIT] | fault_mask_ff[famsr_pkg::MASK_AUXV_BIT];

    // Combine each source group with its mask bit.
    always_comb
    begin
        nxt_fault = (ovolt_s & ~fault_mask_ff[famsr_pkg::MASK_OVOLT_BIT])
                  | (ocurr_s & ~fault_mask_ff[famsr_pkg::MASK_OCURR_BIT])
                  | (cmem_s & ~fault_mask_ff[famsr_pkg::MASK_CMEM_BIT])
                  | (opwr_s & ~fault_mask_ff[famsr_pkg::MASK_OPWR_BIT]);
        nxt_alert = (cmem_s & ~alert_mask_ff[famsr_pkg::MASK_CMEM_BIT])
                  | (auxv_s & ~auxv_masked)
                  | (opwr_s & ~alert_mask_ff[famsr_pkg::MASK_OPWR_BIT]);
    end

    // Register the indications so the outputs come from flip-flops.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            fault_o <= 1'b0;
            alert_o <= 1'b0;
        end
        else
        begin
            fault_o <= nxt_fault;
            alert_o <= nxt_alert;
        end
    end

    // ------------------------------------------------------------------
    // Status bytes
    // ------------------------------------------------------------------
    logic [7:0] gen_status;   // General status byte.
    logic [7:0] phase_status; // Phase status byte.
    logic [7:0] status_word;  // Low byte of the status word.

    // Assemble the read-only bytes; unlisted bits stay zero.
    always_comb
    begin
        gen_status = 8'h00;
        gen_status[famsr_pkg::GEN_FAULT_BIT] = fault_o;
        gen_status[famsr_pkg::GEN_ALERT_BIT] = alert_o;
        gen_status[famsr_pkg::GEN_READY_BIT] = ready_s;
        phase_status = 8'h00;
        phase_status[famsr_pkg::PH_FOURTH_BIT] = pins_s[famsr_pkg::SRC_PH4];
        phase_status[famsr_pkg::PH_THIRD_BIT] = pins_s[famsr_pkg::SRC_PH3];
        phase_status[famsr_pkg::PH_SECOND_BIT] = pins_s[famsr_pkg::SRC_PH2];
        phase_status[famsr_pkg::PH_PSAVE_BIT] = psave_s;
        status_word = 8'h00;
        status_word[famsr_pkg::SW_PGOOD_BIT] = pgood_s;
    end

    // ------------------------------------------------------------------
    // Command answer
    // ------------------------------------------------------------------
    // Every command is answered one cycle later; unknown codes and writes to
    // read-only bytes are flagged and change nothing.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= 8'h00;
            rsp_err_o <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= cmd_valid_i;
            rsp_err_o <= 1'b0;
            rsp_rdata_o <= 8'h00;
            if (!cmd_valid_i)
            begin
                rsp_err_o <= 1'b0;
            end
            else if (cmd_write_i)
            begin
                rsp_err_o <= !(wr_alert || wr_fault);
            end
            else if (cmd_code_i == famsr_pkg::CMD_ALERT_MASK)
            begin
                rsp_rdata_o <= alert_mask_ff;
            end
            else if (cmd_code_i == famsr_pkg::CMD_FAULT_MASK)
            begin
                rsp_rdata_o <= fault_mask_ff;
            end
            else if (cmd_code_i == famsr_pkg::CMD_GEN_STATUS)
            begin
                rsp_rdata_o <= gen_status;
            end
            else if (cmd_code_i == famsr_pkg::CMD_PHASE_STATUS)
            begin
                rsp_rdata_o <= phase_status;
            end
            else if (cmd_code_i == famsr_pkg::CMD_STATUS_WORD)
            begin
                rsp_rdata_o <= status_word;
            end
            else
            begin
                rsp_err_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    logic rd_valid; // Read command this cycle.
    assign rd_valid = cmd_valid_i && !cmd_write_i;

    chk_alert_cml_mask: assert property (
        alert_mask_ff[famsr_pkg::MASK_CMEM_BIT] && cmem_s && !auxv_s && !opwr_s |=> !alert_o
    ) else $error("Masked comm alert still raised alert.");

    chk_alert_auxv_mask: assert property (
        auxv_s && !cmem_s && !opwr_s |=> (alert_o == !$past(auxv_masked))
    ) else $error("Voltage monitor alert does not follow its mask.");

    chk_alert_opwr_mask: assert property (
        opwr_s && !cmem_s && !auxv_s |=> (alert_o == !$past(alert_mask_ff[famsr_pkg::MASK_OPWR_BIT]))
    ) else $error("Output power alert does not follow its mask.");

    chk_fault_ovolt_mask: assert property (
        ovolt_s && !ocurr_s && !cmem_s && !opwr_s
        |=> (fault_o == !$past(fault_mask_ff[famsr_pkg::MASK_OVOLT_BIT]))
    ) else $error("Output voltage fault does not follow its mask.");

    chk_fault_ocurr_mask: assert property (
        fault_mask_ff[famsr_pkg::MASK_OCURR_BIT] && ocurr_s && !ovolt_s && !cmem_s && !opwr_s |=> !fault_o
    ) else $error("Masked current fault still raised fault.");

    chk_fault_cmem_mask: assert property (
        fault_mask_ff[famsr_pkg::MASK_CMEM_BIT] && cmem_s && !ovolt_s && !ocurr_s && !opwr_s |=> !fault_o
    ) else $error("Masked comm fault still raised fault.");

    chk_fault_opwr_mask: assert property (
        opwr_s && !ovolt_s && !ocurr_s && !cmem_s
        |=> (fault_o == !$past(fault_mask_ff[famsr_pkg::MASK_OPWR_BIT]))
    ) else $error("Output power fault does not follow its mask.");

    chk_status_word_pgood: assert property (
        rd_valid && cmd_code_i == famsr_pkg::CMD_STATUS_WORD
        |=> rsp_valid_o && rsp_rdata_o == {4'h0, $past(pgood_s), 3'h0}
    ) else $error("Status word read does not show power good at bit 3.");

    chk_phase_read: assert property (
        rd_valid && cmd_code_i == famsr_pkg::CMD_PHASE_STATUS
        |=> rsp_rdata_o == {2'h0, $past(pins_s[famsr_pkg::SRC_PH4]), $past(pins_s[famsr_pkg::SRC_PH3]),
                            $past(pins_s[famsr_pkg::SRC_PH2]), $past(psave_s), 2'h0}
    ) else $error("Phase status read is wrong.");

    chk_general_read: assert property (
        rd_valid && cmd_code_i == famsr_pkg::CMD_GEN_STATUS
        |=> rsp_rdata_o == {$past(fault_o), $past(alert_o), 1'b0, $past(ready_s), 4'h0}
    ) else $error("General status read is wrong.");

    chk_mask_write_read: assert property (
        wr_fault ##1 (rd_valid && cmd_code_i == famsr_pkg::CMD_FAULT_MASK)
        |=> rsp_rdata_o == ($past(cmd_wdata_i, 2) & famsr_pkg::FAULT_MASK_WR)
    ) else $error("Fault mask readback does not match the write.");

endmodule : famsr_regs

// >>> hdl/famsr_pkg.sv
// Package with command codes, field positions and reset values of the mask and status bytes.
package famsr_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_STATUS_WORD = 8'hF8;  // Low byte of the status word.
    localparam logic [7:0] CMD_ALERT_MASK = 8'hF9;   // Alert mask byte.
    localparam logic [7:0] CMD_FAULT_MASK = 8'hFA;   // Fault mask byte.
    localparam logic [7:0] CMD_GEN_STATUS = 8'hFB;   // General status byte.
    localparam logic [7:0] CMD_PHASE_STATUS = 8'hFC; // Phase status byte.

    // ------------------------------------------------------------------
    // Reset values and writable bits
    // ------------------------------------------------------------------
    localparam logic [7:0] ALERT_MASK_RST = 8'h00;   // Alert mask after reset.
    localparam logic [7:0] FAULT_MASK_RST = 8'h00;   // Fault mask after reset.
    localparam logic [7:0] ALERT_MASK_WR = 8'h0D;    // Implemented bits of the alert mask.
    localparam logic [7:0] FAULT_MASK_WR = 8'hCD;    // Implemented bits of the fault mask.

    // ------------------------------------------------------------------
    // Mask byte fields
    // ------------------------------------------------------------------
    localparam int unsigned MASK_OVOLT_BIT = 7;      // Output voltage group.
    localparam int unsigned MASK_OCURR_BIT = 6;      // Output current group.
    localparam int unsigned MASK_CMEM_BIT = 3;       // Communication, memory and logic group.
    localparam int unsigned MASK_AUXV_BIT = 2;       // Auxiliary voltage monitor limits.
    localparam int unsigned MASK_OPWR_BIT = 0;       // Output power limit.

    // ------------------------------------------------------------------
    // Status byte fields
    // ------------------------------------------------------------------
    localparam int unsigned GEN_FAULT_BIT = 7;       // Fault indication.
    localparam int unsigned GEN_ALERT_BIT = 6;       // Alert indication.
    localparam int unsigned GEN_READY_BIT = 4;       // Device ready.
    localparam int unsigned PH_FOURTH_BIT = 5;       // Fourth phase enabled.
    localparam int unsigned PH_THIRD_BIT = 4;        // Third phase enabled.
    localparam int unsigned PH_SECOND_BIT = 3;       // Second phase enabled.
    localparam int unsigned PH_PSAVE_BIT = 2;        // Power save request asserted.
    localparam int unsigned SW_PGOOD_BIT = 3;        // Power good in the status word.

    // ------------------------------------------------------------------
    // Positions of the input pins in the synchroniser vector
    // ------------------------------------------------------------------
    localparam int unsigned SRC_OVOLT = 0;
    localparam int unsigned SRC_OCURR = 1;
    localparam int unsigned SRC_CMEM = 2;
    localparam int unsigned SRC_AUXV = 3;
    localparam int unsigned SRC_OPWR = 4;
    localparam int unsigned SRC_PGOOD = 5;
    localparam int unsigned SRC_READY = 6;
    localparam int unsigned SRC_PH2 = 7;
    localparam int unsigned SRC_PH3 = 8;
    localparam int unsigned SRC_PH4 = 9;
    localparam int unsigned SRC_PSAVE_N = 10;
    localparam int unsigned SRC_COUNT = 11;

    // Level the power save pin shows while idle, so its synchroniser starts deasserted.
    localparam logic [10:0] SRC_RST = 11'h400;

endpackage : famsr_pkg

// >>> hdl/famsr_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps

module famsr_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic srst_i,
    // Asynchronous levels in
    input wire logic [WIDTH-1:0] async_i,
    // Settled levels out
    output logic [WIDTH-1:0] sync_o
);

    // ------------------------------------------------------------------
    // Stages
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] stage1_ff; // First stage, read only by the second.
    logic [WIDTH-1:0] stage2_ff; // Second stage.
    logic [WIDTH-1:0] stage3_ff; // Third stage.
    logic [WIDTH-1:0] settled_ff; // Accepted level.

    // Shift the pins through the three stages.
    always_ff @(posedge sys_clk_i)
    begin
        if (srst_i)
        begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
            stage3_ff <= RST_VAL;
        end
        else
        begin
            stage1_ff <= async_i;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
        end
    end

    // Each bit is accepted only when the last two stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            always_ff @(posedge sys_clk_i)
            begin
                if (srst_i)
                begin
                    settled_ff[gi] <= RST_VAL[gi];
                end
                else if (stage2_ff[gi] == stage3_ff[gi])
                begin
                    settled_ff[gi] <= stage3_ff[gi];
                end
            end
        end
    endgenerate

    assign sync_o = settled_ff;

endmodule : famsr_sync

// >>> tb/famsr_host_model.sv
// Behavioural host that issues single-byte commands on the command port.
`timescale 1ns/100ps

module famsr_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Command request
    output logic cmd_valid_o,
    output logic cmd_write_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] cmd_wdata_o,
    // Command answer
    input wire logic rsp_valid_i,
    input wire logic [7:0] rsp_rdata_i,
    input wire logic rsp_err_i
);
    // Code and data lines start at a pattern; valid and write start at zero.
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b0;
        cmd_code_o = 8'h5A;
        cmd_wdata_o = 8'hA5;
    end

    // Issues one command and waits a bounded number of cycles for its answer.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [7:0] wd,
        output logic [7:0] rd, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        rd = 8'h00;
        err = 1'b0;
        @(posedge sys_clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_write_o = wr;
        cmd_code_o = code;
        cmd_wdata_o = wd;
        @(posedge sys_clk_i);
        #1;
        // Released lines show the inverse so a stale value is never mistaken for a live one.
        cmd_valid_o = 1'b0;
        cmd_write_o = ~wr;
        cmd_code_o = ~code;
        cmd_wdata_o = ~wd;
        for (n = 0; n < 4 && !ok; n++)
        begin
            if (rsp_valid_i === 1'b1)
            begin
                rd = rsp_rdata_i;
                err = rsp_err_i;
                ok = 1'b1;
            end
            else
            begin
                @(posedge sys_clk_i);
                #1;
            end
        end
    endtask : xfer

    // Issues a write and, on the very next cycle, a read of the same code.
    task automatic xfer_wr_rd(input logic [7:0] code, input logic [7:0] wd,
        output logic [7:0] rd, output logic err, output logic ok);
        @(posedge sys_clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_write_o = 1'b1;
        cmd_code_o = code;
        cmd_wdata_o = wd;
        @(posedge sys_clk_i);
        #1;
        // The request stays up; only its direction and data change for the read.
        cmd_write_o = 1'b0;
        cmd_wdata_o = ~wd;
        ok = (rsp_valid_i === 1'b1);
        err = rsp_err_i;
        @(posedge sys_clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_write_o = 1'b1;
        cmd_code_o = ~code;
        ok = ok && (rsp_valid_i === 1'b1);
        err = err | rsp_err_i;
        rd = rsp_rdata_i;
    endtask : xfer_wr_rd
endmodule : famsr_host_model

// >>> tb/famsr_regs_test.sv
// Self-checking testbench for the mask and status command registers.
`timescale 1ns/100ps

module famsr_regs_test;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic sys_clk_i = 1'b0; // System clock, 100 ns period.
    logic srst_i = 1'b1; // Synchronous reset.
    logic cmd_valid, cmd_write, rsp_valid, rsp_err, fault, alert;
    logic [7:0] cmd_code, cmd_wdata, rsp_rdata;
    logic [4:0] flags = 5'h00; // Output voltage, current, comm/memory/logic, monitor, power.
    logic power_good = 1'b0;
    logic ready = 1'b0;
    logic [3:0] phase_pins = 4'h1; // Phase 4, 3, 2 enables and the active-low power save pin.
    int num_errors = 0;
    int samples_checked = 0;

    initial
    begin
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    famsr_regs u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write),
        .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata),
        .rsp_err_o(rsp_err), .output_voltage_flag_i(flags[0]), .output_current_flag_i(flags[1]),
        .comm_memory_logic_status_i(flags[2]), .aux_voltage_monitor_flag_i(flags[3]),
        .output_power_flag_i(flags[4]), .power_good_i(power_good), .ready_i(ready),
        .phase2_en_i(phase_pins[1]), .phase3_en_i(phase_pins[2]), .phase4_en_i(phase_pins[3]),
        .power_save_request_n_i(phase_pins[0]), .fault_o(fault), .alert_o(alert));

    famsr_host_model u_host (.sys_clk_i(sys_clk_i), .cmd_valid_o(cmd_valid), .cmd_write_o(cmd_write),
        .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata), .rsp_valid_i(rsp_valid), .rsp_rdata_i(rsp_rdata),
        .rsp_err_i(rsp_err));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    // Prints the verdict and ends the run.
    task automatic summarize();
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // Compares one byte and counts the result.
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check8

    // Runs one command, checks its error flag and returns the read byte.
    task automatic acc(input logic wr, input logic [7:0] code, input logic [7:0] wd, input logic exp_err,
        output logic [7:0] rd);
        logic err, ok;
        u_host.xfer(wr, code, wd, rd, err, ok);
        if (!ok)
        begin
            num_errors++;
            $display("Error response valid expected 1 seen 0");
            summarize();
        end
        else
        begin
            check8("response error flag", {7'h00, exp_err}, {7'h00, err});
        end
    endtask : acc

    // Lets pin changes cross the synchroniser and reach the outputs.
    task automatic settle();
        repeat (6) @(posedge sys_clk_i);
        #1;
    endtask : settle

    // ------------------------------------------------------------------
    // Mask table: source pin, mask command, mask bit, 1 for fault output
    // ------------------------------------------------------------------
    int src_tab[8] = '{0, 1, 2, 4, 2, 3, 3, 4};
    logic [7:0] code_tab[8] = '{8'hFA, 8'hFA, 8'hFA, 8'hFA, 8'hF9, 8'hF9, 8'hFA, 8'hF9};
    int bit_tab[8] = '{7, 6, 3, 0, 3, 2, 2, 0};
    logic kind_tab[8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

    // Main sequence.
    initial
    begin
        logic [7:0] rd;
        logic [7:0] wbit;
        logic err;
        logic ok;
        repeat (12) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
        // Reset values and reserved bits of the writable and read-only bytes.
        acc(1'b0, famsr_pkg::CMD_FAULT_MASK, 8'h00, 1'b0, rd);
        check8("fault mask reset", 8'h00, rd);
        acc(1'b0, famsr_pkg::CMD_ALERT_MASK, 8'h00, 1'b0, rd);
        check8("alert mask reset", 8'h00, rd);
        acc(1'b0, famsr_pkg::CMD_GEN_STATUS, 8'h00, 1'b0, rd);
        check8("general status reset", 8'h00, rd);
        acc(1'b1, famsr_pkg::CMD_FAULT_MASK, 8'hFF, 1'b0, rd);
        acc(1'b0, famsr_pkg::CMD_FAULT_MASK, 8'h00, 1'b0, rd);
        check8("fault mask all ones", 8'hCD, rd);
        acc(1'b1, famsr_pkg::CMD_ALERT_MASK, 8'hFF, 1'b0, rd);
        acc(1'b0, famsr_pkg::CMD_ALERT_MASK, 8'h00, 1'b0, rd);
        check8("alert mask all ones", 8'h0D, rd);
        // A reset in mid-run brings the written fault mask back to zero.
        srst_i = 1'b1;
        repeat (6) @(posedge sys_clk_i);
        #1;
        srst_i = 1'b0;
        acc(1'b0, famsr_pkg::CMD_FAULT_MASK, 8'h00, 1'b0, rd);
        check8("fault mask after reset", 8'h00, rd);
        acc(1'b1, famsr_pkg::CMD_PHASE_STATUS, 8'hFF, 1'b1, rd);
        acc(1'b1, famsr_pkg::CMD_GEN_STATUS, 8'hFF, 1'b1, rd);
        acc(1'b0, 8'h10, 8'h00, 1'b1, rd);
        // A write followed at once by a read of the same mask returns the implemented bits.
        u_host.xfer_wr_rd(famsr_pkg::CMD_FAULT_MASK, 8'hB7, rd, err, ok);
        check8("back to back answers", 8'h01, {7'h00, ok});
        check8("back to back error flag", 8'h00, {7'h00, err});
        check8("fault mask back to back", 8'h85, rd);
        // Each source raises its indication until its mask bit is set.
        for (int i = 0; i < 8; i++)
        begin
            wbit = 8'h01 << bit_tab[i];
            acc(1'b1, famsr_pkg::CMD_FAULT_MASK, 8'h00, 1'b0, rd);
            acc(1'b1, famsr_pkg::CMD_ALERT_MASK, 8'h00, 1'b0, rd);
            flags = 5'h01 << src_tab[i];
            settle();
            check8("indication unmasked", 8'h01, {7'h00, kind_tab[i] ? fault : alert});
            acc(1'b0, famsr_pkg::CMD_GEN_STATUS, 8'h00, 1'b0, rd);
            check8("status indication bit", 8'h01, {7'h00, rd[kind_tab[i] ? 7 : 6]});
            acc(1'b1, code_tab[i], wbit, 1'b0, rd);
            @(posedge sys_clk_i);
            #1;
            check8("indication masked", 8'h00, {7'h00, kind_tab[i] ? fault : alert});
            flags = 5'h00;
            settle();
        end
        // Phase status follows every combination of the phase and power save pins.
        for (int i = 0; i < 16; i++)
        begin
            phase_pins = 4'(i);
            settle();
            acc(1'b0, famsr_pkg::CMD_PHASE_STATUS, 8'h00, 1'b0, rd);
            check8("phase status", {2'b00, phase_pins[3:1], ~phase_pins[0], 2'b00}, rd);
        end
        // Power good lives in the status word; ready shows in the general status.
        power_good = 1'b1;
        ready = 1'b1;
        settle();
        acc(1'b0, famsr_pkg::CMD_STATUS_WORD, 8'h00, 1'b0, rd);
        check8("status word", 8'h08, rd);
        acc(1'b0, famsr_pkg::CMD_GEN_STATUS, 8'h00, 1'b0, rd);
        check8("general status ready", 8'h10, rd);
        summarize();
    end
endmodule : famsr_regs_test
